// >>> logic/muldiv_consts.svh
// constants for the multiply/divide unit and its cpu end
`ifndef MULDIV_CONSTS_SVH
`define MULDIV_CONSTS_SVH
`define ACC_SEL_LOW 2'h0
`define ACC_SEL_HIGH 2'h1
`define ACC_SEL_CTRL 2'h2
`define CTRL_RESET 16'h0000
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 2
`define CTRL_RESUME_BIT 3
`define CTRL_IN_USE_BIT 4
`define CTRL_STEP_LSB 8
`define CTRL_STEP_MSB 12
`define CTRL_SAVE_VALUE 16'h0010
`define MUL_STEPS 5'h11
`define DIV_STEPS 5'h10
`define LAST_STEP 5'h01
`define SIGNED_MIN_MAG 16'h8000
`endif

// >>> logic/muldiv_pkg.sv
// types shared by the multiply/divide unit and its cpu end
package muldiv_pkg;
  typedef enum logic [2:0] {
    unsigned_product_op = 3'b000,
    signed_product_op = 3'b001,
    unsigned_short_quotient_op = 3'b010,
    signed_short_quotient_op = 3'b011,
    unsigned_quotient_op = 3'b100,
    signed_quotient_op = 3'b101
  } op_type;
  typedef enum logic [1:0] {
    unit_idle = 2'b00,
    unit_mul = 2'b01,
    unit_div = 2'b10,
    unit_finish = 2'b11
  } unit_state_type;
  typedef enum logic [3:0] {
    cpu_idle = 4'b0000,
    cpu_wait = 4'b0001,
    cpu_rd_high = 4'b0010,
    cpu_rd_low = 4'b0011,
    cpu_save_rd = 4'b0100,
    cpu_save_wr = 4'b0101,
    cpu_restore = 4'b0110,
    cpu_interrupt_return_op = 4'b0111,
    cpu_interrupt_return_op_wait = 4'b1000
  } cpu_state_type;
endpackage

// >>> logic/muldiv_if.sv
// link between the cpu pipeline end and the multiply/divide unit
`timescale 1ns/10ps
`default_nettype none
interface muldiv_if;
  logic op_start;
  muldiv_pkg::op_type op_code;
  logic [15:0] op_addr;
  logic [15:0] operand_a;
  logic [15:0] operand_b;
  logic acc_wr;
  logic acc_rd;
  logic [1:0] acc_sel;
  logic [15:0] acc_wdata;
  logic int_break;
  logic interrupt_return_op_req;
  logic mip_load;
  logic mip_value;
  logic busy;
  logic done;
  logic [15:0] rdata;
  logic rvalid;
  logic too_wide;
  logic mip_flag;
  logic [15:0] ret_addr;
  logic interrupt_return_op_ack;
  logic refetch;
  modport unit_mp (
    input op_start, op_code, op_addr, operand_a, operand_b, acc_wr, acc_rd, acc_sel,
    input acc_wdata, int_break, interrupt_return_op_req, mip_load, mip_value,
    output busy, done, rdata, rvalid, too_wide, mip_flag, ret_addr, interrupt_return_op_ack, refetch
  );
  modport cpu_mp (
    output op_start, op_code, op_addr, operand_a, operand_b, acc_wr, acc_rd, acc_sel,
    output acc_wdata, int_break, interrupt_return_op_req, mip_load, mip_value,
    input busy, done, rdata, rvalid, too_wide, mip_flag, ret_addr, interrupt_return_op_ack, refetch
  );
endinterface
`default_nettype wire

// >>> logic/muldiv_unit.sv
// multiply/divide unit: accumulator, control register and iterative datapath
`timescale 1ns/10ps
`default_nettype none
`include "muldiv_consts.svh"
module muldiv_unit (
  input wire logic mclk_i,
  input wire logic resetn_i,
  muldiv_if.unit_mp link,
  output logic [15:0] control_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] mag16(input logic [15:0] v, input logic neg);
    mag16 = neg ? 16'(-v) : v;
  endfunction
  function automatic logic [31:0] mag32(input logic [31:0] v, input logic neg);
    mag32 = neg ? 32'(-v) : v;
  endfunction
  function automatic logic is_signed_op(input muldiv_pkg::op_type op);
    is_signed_op = (op == muldiv_pkg::signed_product_op) ||
      (op == muldiv_pkg::signed_short_quotient_op) || (op == muldiv_pkg::signed_quotient_op);
  endfunction
  function automatic logic is_mul_op(input muldiv_pkg::op_type op);
    is_mul_op = (op == muldiv_pkg::unsigned_product_op) ||
      (op == muldiv_pkg::signed_product_op);
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] accum_low_half;
  logic [15:0] accum_high_half;
  logic [15:0] ctrl;
  muldiv_pkg::unit_state_type state;
  muldiv_pkg::op_type op_q;
  logic [4:0] step;
  logic [17:0] booth_a;
  logic [16:0] booth_q;
  logic booth_q1;
  logic [17:0] mcand;
  logic [16:0] rem;
  logic [15:0] quot;
  logic [15:0] dvs;
  logic neg_q;
  logic neg_r;
  logic div_ovf;
  logic sgn;
  logic [31:0] dividend;
  logic [31:0] dvd_mag;
  logic [15:0] dvs_mag;
  logic neg_dvd;
  logic neg_dvs;
  logic [17:0] booth_sum;
  logic [16:0] div_trial;
  logic [31:0] prod;
  logic [31:0] result;
  logic result_wide;
  logic start_ok;
  logic break_ok;
  logic [15:0] q_signed;
  logic [15:0] r_signed;

  assign control_o = ctrl;
  assign start_ok = link.op_start && (state == muldiv_pkg::unit_idle);
  assign break_ok = link.int_break &&
    ((state == muldiv_pkg::unit_mul) || (state == muldiv_pkg::unit_div));

  // ----------------------------------------
  // operand preparation
  // ----------------------------------------
  always_comb
  begin
    sgn = is_signed_op(link.op_code);
    if (link.op_code == muldiv_pkg::unsigned_quotient_op ||
        link.op_code == muldiv_pkg::signed_quotient_op)
      dividend = {accum_high_half, accum_low_half};
    else
      dividend = {(sgn ? {16{accum_low_half[15]}} : 16'h0000), accum_low_half};
    neg_dvd = sgn && dividend[31];
    neg_dvs = sgn && link.operand_b[15];
    dvd_mag = mag32(dividend, neg_dvd);
    dvs_mag = mag16(link.operand_b, neg_dvs);
  end

  // ----------------------------------------
  // iteration and result
  // ----------------------------------------
  always_comb
  begin
    unique case ({booth_q[0], booth_q1})
      2'b01: booth_sum = booth_a + mcand;
      2'b10: booth_sum = booth_a - mcand;
      default: booth_sum = booth_a;
    endcase
    div_trial = {rem[15:0], quot[15]};
    prod = {booth_a[14:0], booth_q};
    q_signed = neg_q ? 16'(-quot) : quot;
    r_signed = neg_r ? 16'(-rem[15:0]) : rem[15:0];
    if (is_mul_op(op_q))
    begin
      result = prod;
      if (is_signed_op(op_q))
        result_wide = prod[31:16] != {16{prod[15]}};
      else
        result_wide = |prod[31:16];
    end
    else
    begin
      result = {r_signed, q_signed};
      result_wide = div_ovf || (is_signed_op(op_q) && ((quot > `SIGNED_MIN_MAG) ||
        ((quot == `SIGNED_MIN_MAG) && !neg_q)));
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= muldiv_pkg::unit_idle;
      op_q <= muldiv_pkg::unsigned_product_op;
      step <= 5'h00;
      booth_a <= 18'h00000;
      booth_q <= 17'h00000;
      booth_q1 <= 1'b0;
      mcand <= 18'h00000;
      rem <= 17'h00000;
      quot <= 16'h0000;
      dvs <= 16'h0000;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      div_ovf <= 1'b0;
      link.busy <= 1'b0;
      link.done <= 1'b0;
    end
    else
    begin
      link.done <= 1'b0;
      unique case (state)
        muldiv_pkg::unit_idle:
        begin
          if (start_ok)
          begin
            op_q <= link.op_code;
            link.busy <= 1'b1;
            if (is_mul_op(link.op_code))
            begin
              // booth over 17-bit sign or zero extended operands
              mcand <= {{2{sgn & link.operand_a[15]}}, link.operand_a};
              booth_q <= {sgn & link.operand_b[15], link.operand_b};
              booth_a <= 18'h00000;
              booth_q1 <= 1'b0;
              step <= `MUL_STEPS;
              state <= muldiv_pkg::unit_mul;
            end
            else
            begin
              rem <= {1'b0, dvd_mag[31:16]};
              quot <= dvd_mag[15:0];
              dvs <= dvs_mag;
              neg_q <= neg_dvd ^ neg_dvs;
              neg_r <= neg_dvd;
              div_ovf <= (dvs_mag == 16'h0000) || (dvd_mag[31:16] >= dvs_mag);
              step <= `DIV_STEPS;
              if ((dvs_mag == 16'h0000) || (dvd_mag[31:16] >= dvs_mag))
                state <= muldiv_pkg::unit_finish;
              else
                state <= muldiv_pkg::unit_div;
            end
          end
        end
        muldiv_pkg::unit_mul, muldiv_pkg::unit_div:
        begin
          if (break_ok)
          begin
            state <= muldiv_pkg::unit_idle;
            link.busy <= 1'b0;
          end
          else
          begin
            if (state == muldiv_pkg::unit_mul)
              {booth_a, booth_q, booth_q1} <= {booth_sum[17], booth_sum, booth_q};
            else if (div_trial >= {1'b0, dvs})
            begin
              rem <= 17'(div_trial - {1'b0, dvs});
              quot <= {quot[14:0], 1'b1};
            end
            else
            begin
              rem <= div_trial;
              quot <= {quot[14:0], 1'b0};
            end
            step <= 5'(step - 5'h01);
            if (step == `LAST_STEP)
              state <= muldiv_pkg::unit_finish;
          end
        end
        muldiv_pkg::unit_finish:
        begin
          state <= muldiv_pkg::unit_idle;
          link.busy <= 1'b0;
          link.done <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // accumulator halves
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      accum_low_half <= 16'h0000;
      accum_high_half <= 16'h0000;
    end
    else if (state == muldiv_pkg::unit_finish)
    begin
      if (!(div_ovf && !is_mul_op(op_q)))
        {accum_high_half, accum_low_half} <= result;
    end
    else if (link.acc_wr && link.acc_sel == `ACC_SEL_LOW)
      accum_low_half <= link.acc_wdata;
    else if (link.acc_wr && link.acc_sel == `ACC_SEL_HIGH)
      accum_high_half <= link.acc_wdata;
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ctrl <= `CTRL_RESET;
    else
    begin
      if (link.acc_wr && link.acc_sel == `ACC_SEL_CTRL)
        ctrl <= link.acc_wdata;
      if (break_ok)
      begin
        ctrl[`CTRL_OP_MSB:`CTRL_OP_LSB] <= op_q;
        ctrl[`CTRL_STEP_MSB:`CTRL_STEP_LSB] <= step;
        ctrl[`CTRL_RESUME_BIT] <= 1'b1;
      end
      else if (link.done)
        ctrl[`CTRL_RESUME_BIT] <= 1'b0;
      // set wins over the clear by a low-half read
      if (start_ok || (link.acc_wr && link.acc_sel != `ACC_SEL_CTRL))
        ctrl[`CTRL_IN_USE_BIT] <= 1'b1;
      else if (link.acc_rd && link.acc_sel == `ACC_SEL_LOW)
        ctrl[`CTRL_IN_USE_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------
  // status flags and return address
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      link.too_wide <= 1'b0;
      link.mip_flag <= 1'b0;
      link.ret_addr <= 16'h0000;
      link.interrupt_return_op_ack <= 1'b0;
      link.refetch <= 1'b0;
    end
    else
    begin
      link.interrupt_return_op_ack <= link.interrupt_return_op_req;
      link.refetch <= link.interrupt_return_op_req && link.mip_flag;
      if (state == muldiv_pkg::unit_finish)
        link.too_wide <= result_wide;
      if (start_ok)
        link.ret_addr <= link.op_addr;
      if (break_ok)
        link.mip_flag <= 1'b1;
      else if (link.interrupt_return_op_req)
        link.mip_flag <= 1'b0;
      else if (link.mip_load)
        link.mip_flag <= link.mip_value;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      link.rdata <= 16'h0000;
      link.rvalid <= 1'b0;
    end
    else
    begin
      link.rvalid <= link.acc_rd;
      if (link.acc_rd)
      begin
        unique case (link.acc_sel)
          `ACC_SEL_LOW: link.rdata <= accum_low_half;
          `ACC_SEL_HIGH: link.rdata <= accum_high_half;
          `ACC_SEL_CTRL: link.rdata <= ctrl;
          default: link.rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/muldiv_cpu_end.sv
// cpu pipeline end: issues operations, reads results, saves and restores context
`timescale 1ns/10ps
`default_nettype none
`include "muldiv_consts.svh"
module muldiv_cpu_end (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic user_start_i,
  input wire muldiv_pkg::op_type user_op_i,
  input wire logic [15:0] user_addr_i,
  input wire logic [15:0] user_a_i,
  input wire logic [15:0] user_b_i,
  input wire logic user_write_i,
  input wire logic [1:0] user_sel_i,
  input wire logic [15:0] user_wdata_i,
  input wire logic user_read_result_i,
  input wire logic user_irq_i,
  input wire logic user_save_i,
  input wire logic user_interrupt_return_op_i,
  input wire logic user_task_switch_i,
  input wire logic user_task_mip_i,
  output logic user_busy_o,
  output logic user_done_o,
  output logic [31:0] user_result_o,
  output logic user_result_valid_o,
  output logic user_too_wide_o,
  output logic user_refetch_o,
  output logic [15:0] user_ret_addr_o,
  muldiv_if.cpu_mp link
);
  muldiv_pkg::cpu_state_type state;
  logic [15:0] saved_ctrl;
  logic saved_valid;
  muldiv_pkg::op_type last_op;
  logic [15:0] last_a;
  logic [15:0] last_b;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= muldiv_pkg::cpu_idle;
      saved_ctrl <= `CTRL_RESET;
      saved_valid <= 1'b0;
      last_op <= muldiv_pkg::unsigned_product_op;
      last_a <= 16'h0000;
      last_b <= 16'h0000;
      link.op_start <= 1'b0;
      link.op_code <= muldiv_pkg::unsigned_product_op;
      link.op_addr <= 16'h0000;
      link.operand_a <= 16'h0000;
      link.operand_b <= 16'h0000;
      link.acc_wr <= 1'b0;
      link.acc_rd <= 1'b0;
      link.acc_sel <= `ACC_SEL_LOW;
      link.acc_wdata <= 16'h0000;
      link.int_break <= 1'b0;
      link.interrupt_return_op_req <= 1'b0;
      link.mip_load <= 1'b0;
      link.mip_value <= 1'b0;
      user_busy_o <= 1'b0;
      user_done_o <= 1'b0;
      user_result_o <= 32'h00000000;
      user_result_valid_o <= 1'b0;
      user_too_wide_o <= 1'b0;
      user_refetch_o <= 1'b0;
      user_ret_addr_o <= 16'h0000;
    end
    else
    begin
      link.op_start <= 1'b0;
      link.acc_wr <= 1'b0;
      link.acc_rd <= 1'b0;
      link.int_break <= 1'b0;
      link.interrupt_return_op_req <= 1'b0;
      link.mip_load <= 1'b0;
      user_done_o <= 1'b0;
      user_result_valid_o <= 1'b0;
      user_refetch_o <= 1'b0;
      unique case (state)
        muldiv_pkg::cpu_idle:
        begin
          user_busy_o <= 1'b0;
          if (user_start_i)
          begin
            link.op_start <= 1'b1;
            link.op_code <= user_op_i;
            link.op_addr <= user_addr_i;
            link.operand_a <= user_a_i;
            link.operand_b <= user_b_i;
            last_op <= user_op_i;
            last_a <= user_a_i;
            last_b <= user_b_i;
            user_busy_o <= 1'b1;
            state <= muldiv_pkg::cpu_wait;
          end
          else if (user_write_i)
          begin
            link.acc_wr <= 1'b1;
            link.acc_sel <= user_sel_i;
            link.acc_wdata <= user_wdata_i;
          end
          else if (user_read_result_i)
          begin
            link.acc_rd <= 1'b1;
            link.acc_sel <= `ACC_SEL_HIGH;
            user_busy_o <= 1'b1;
            state <= muldiv_pkg::cpu_rd_high;
          end
          else if (user_save_i)
          begin
            link.acc_rd <= 1'b1;
            link.acc_sel <= `ACC_SEL_CTRL;
            user_busy_o <= 1'b1;
            state <= muldiv_pkg::cpu_save_rd;
          end
          else if (user_interrupt_return_op_i)
          begin
            user_busy_o <= 1'b1;
            if (saved_valid)
            begin
              link.acc_wr <= 1'b1;
              link.acc_sel <= `ACC_SEL_CTRL;
              link.acc_wdata <= saved_ctrl;
              state <= muldiv_pkg::cpu_restore;
            end
            else
              state <= muldiv_pkg::cpu_interrupt_return_op;
          end
          else if (user_task_switch_i)
          begin
            link.mip_load <= 1'b1;
            link.mip_value <= user_task_mip_i;
          end
        end
        muldiv_pkg::cpu_wait:
        begin
          if (user_irq_i && link.busy)
          begin
            link.int_break <= 1'b1;
            user_ret_addr_o <= link.op_addr;
            state <= muldiv_pkg::cpu_idle;
          end
          else if (link.done)
          begin
            user_done_o <= 1'b1;
            user_too_wide_o <= link.too_wide;
            state <= muldiv_pkg::cpu_idle;
          end
        end
        muldiv_pkg::cpu_rd_high:
        begin
          if (link.rvalid)
          begin
            user_result_o[31:16] <= link.rdata;
            link.acc_rd <= 1'b1;
            link.acc_sel <= `ACC_SEL_LOW;
            state <= muldiv_pkg::cpu_rd_low;
          end
        end
        muldiv_pkg::cpu_rd_low:
        begin
          if (link.rvalid)
          begin
            user_result_o[15:0] <= link.rdata;
            user_result_valid_o <= 1'b1;
            state <= muldiv_pkg::cpu_idle;
          end
        end
        muldiv_pkg::cpu_save_rd:
        begin
          if (link.rvalid)
          begin
            saved_ctrl <= link.rdata;
            saved_valid <= 1'b1;
            link.acc_wr <= 1'b1;
            link.acc_sel <= `ACC_SEL_CTRL;
            link.acc_wdata <= `CTRL_SAVE_VALUE;
            state <= muldiv_pkg::cpu_idle;
          end
        end
        muldiv_pkg::cpu_restore:
        begin
          saved_valid <= 1'b0;
          state <= muldiv_pkg::cpu_interrupt_return_op;
        end
        muldiv_pkg::cpu_interrupt_return_op:
        begin
          link.interrupt_return_op_req <= 1'b1;
          state <= muldiv_pkg::cpu_interrupt_return_op_wait;
        end
        muldiv_pkg::cpu_interrupt_return_op_wait:
        begin
          if (link.interrupt_return_op_ack)
          begin
            if (link.refetch)
            begin
              link.op_start <= 1'b1;
              link.op_code <= last_op;
              link.op_addr <= link.ret_addr;
              link.operand_a <= last_a;
              link.operand_b <= last_b;
              user_refetch_o <= 1'b1;
              user_ret_addr_o <= link.ret_addr;
              state <= muldiv_pkg::cpu_wait;
            end
            else
              state <= muldiv_pkg::cpu_idle;
          end
        end
        default: state <= muldiv_pkg::cpu_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verification/muldiv_chk.sv
// assertions on the link between cpu end and multiply/divide unit
`timescale 1ns/10ps
`default_nettype none
module muldiv_chk (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic op_start,
  input wire muldiv_pkg::op_type op_code,
  input wire logic busy,
  input wire logic done,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [1:0] acc_sel,
  input wire logic int_break,
  input wire logic interrupt_return_op_req,
  input wire logic rvalid,
  input wire logic too_wide,
  input wire logic mip_flag,
  input wire logic interrupt_return_op_ack,
  input wire logic refetch,
  input wire logic [15:0] control_o
);
  // ----
  // sequences and checks
  // ----
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_mul_go;
    op_start && !busy && op_code[2:1] == 2'h0;
  endsequence
  sequence s_finish;
    done && !busy;
  endsequence
  a_mul_multi_cycle: assert property (s_mul_go |=> busy[*8])
    else $error("multiply finished too early");
  a_mul_completes: assert property (s_mul_go |-> ##[17:19] s_finish)
    else $error("multiply completion missing");
  a_done_after_busy: assert property (done |-> !busy && $past(busy))
    else $error("done without busy phase");
  a_in_use_set: assert property ((op_start && !busy) || (acc_wr && acc_sel != 2'h2)
    |=> control_o[4])
    else $error("in-use flag not set");
  a_in_use_clear: assert property (acc_rd && acc_sel == 2'h0 && !acc_wr && !op_start
    |=> !control_o[4])
    else $error("in-use flag not cleared");
  a_read_answer: assert property (acc_rd |=> rvalid)
    else $error("read not answered");
  a_break_flag: assert property (int_break && busy |=> mip_flag && !busy)
    else $error("break did not set progress flag");
  a_interrupt_return_op_refetch: assert property (interrupt_return_op_req |=> interrupt_return_op_ack && !mip_flag
    && refetch == $past(mip_flag))
    else $error("interrupt return answer wrong");
  a_too_wide_at_done: assert property ($changed(too_wide) |-> done)
    else $error("too-wide flag moved without completion");
endmodule
`default_nettype wire

// >>> verification/test_multiply_divide_unit.sv
// self-checking bench for both ends of the multiply/divide link
`timescale 1ns/10ps
`default_nettype none
module test_multiply_divide_unit;
  logic mclk_i;
  logic resetn_i;
  logic irq;
  logic tmip;
  logic [5:0] cmd;
  logic [2:0] opc;
  logic [1:0] sel;
  logic [15:0] addr, a, b, wd, ctrl, ra;
  logic [31:0] res, rr;
  logic busy, tw, rv, rf, dn;
  int dones = 0;
  int errors = 0;
  int tests_run = 0;
  int refs = 0;
  muldiv_if link();
  muldiv_unit u_muldiv_unit (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link),
    .control_o(ctrl));
  muldiv_cpu_end u_muldiv_cpu_end (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .user_start_i(cmd[0]), .user_op_i(muldiv_pkg::op_type'(opc)), .user_addr_i(addr),
    .user_a_i(a), .user_b_i(b), .user_write_i(cmd[1]), .user_sel_i(sel),
    .user_wdata_i(wd), .user_read_result_i(cmd[2]), .user_irq_i(irq),
    .user_save_i(cmd[3]), .user_interrupt_return_op_i(cmd[4]), .user_task_switch_i(cmd[5]),
    .user_task_mip_i(tmip), .user_busy_o(busy), .user_done_o(dn), .user_result_o(rr),
    .user_result_valid_o(rv), .user_too_wide_o(tw), .user_refetch_o(rf),
    .user_ret_addr_o(ra), .link(link));
  muldiv_chk u_muldiv_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .op_start(link.op_start), .op_code(link.op_code), .busy(link.busy),
    .done(link.done), .acc_wr(link.acc_wr), .acc_rd(link.acc_rd),
    .acc_sel(link.acc_sel), .int_break(link.int_break), .interrupt_return_op_req(link.interrupt_return_op_req),
    .rvalid(link.rvalid), .too_wide(link.too_wide), .mip_flag(link.mip_flag),
    .interrupt_return_op_ack(link.interrupt_return_op_ack), .refetch(link.refetch), .control_o(ctrl));
  // ----
  // clock, capture and tasks
  // ----
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    if (rv === 1'b1)
      res <= rr;
    if (rf === 1'b1)
      refs <= refs + 1;
    if (dn === 1'b1)
      dones <= dones + 1;
  end
  task summarize;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task pulse(input int n);
    @(posedge mclk_i);
    cmd[n] <= 1'b1;
    @(posedge mclk_i);
    cmd <= 6'h00;
  endtask
  task idle;
    int n;
    n = 0;
    @(negedge mclk_i);
    while (busy !== 1'b0 && n < 200)
    begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  task start(input logic [2:0] c, input logic [15:0] x, input logic [15:0] y);
    @(posedge mclk_i);
    opc <= c;
    addr <= 16'h0400;
    a <= x;
    b <= y;
    pulse(0);
  endtask
  task op(input logic [2:0] c, input logic [15:0] x, input logic [15:0] y);
    start(c, x, y);
    idle;
  endtask
  task wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge mclk_i);
    sel <= s;
    wd <= d;
    pulse(1);
    idle;
    repeat (2) @(negedge mclk_i);
  endtask
  task rd(input logic [31:0] e);
    pulse(2);
    idle;
    repeat (2) @(negedge mclk_i);
    chk(res, e);
  endtask
  // ----
  // watchdog and tests
  // ----
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    errors++;
    summarize;
  end
  initial
  begin
    resetn_i = 1'b0;
    {irq, tmip, cmd, opc, sel, addr, a, b, wd} = '0;
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    op(3'h0, 16'hFFFF, 16'hFFFF);
    chk(tw, 32'h1);
    rd(32'hFFFE0001);
    chk(ctrl[4], 32'h0);
    op(3'h0, 16'h0003, 16'h0004);
    chk(tw, 32'h0);
    rd(32'h0000000C);
    op(3'h1, 16'hFFFE, 16'h0003);
    rd(32'hFFFFFFFA);
    wr(2'h1, 16'h1234);
    wr(2'h0, 16'h0064);
    chk(ctrl[4], 32'h1);
    op(3'h2, 16'h0000, 16'h0007);
    rd(32'h0002000E);
    wr(2'h0, 16'hFFF9);
    op(3'h3, 16'h0000, 16'h0002);
    rd(32'hFFFFFFFD);
    wr(2'h1, 16'hFFFF);
    wr(2'h0, 16'hFF00);
    op(3'h5, 16'h0000, 16'h0010);
    rd(32'h0000FFF0);
    wr(2'h1, 16'h0005);
    wr(2'h0, 16'h0000);
    op(3'h4, 16'h0000, 16'h0003);
    chk(tw, 32'h1);
    rd(32'h00050000);
    wr(2'h0, 16'h0064);
    start(3'h2, 16'h0000, 16'h0007);
    repeat (4) @(posedge mclk_i);
    irq <= 1'b1;
    repeat (4) @(posedge mclk_i);
    irq <= 1'b0;
    idle;
    chk(ra, 32'h0400);
    chk(ctrl[3], 32'h1);
    pulse(3);
    idle;
    chk(ctrl, 32'h0010);
    pulse(4);
    idle;
    chk(refs, 32'h1);
    rd(32'h0002000E);
    @(posedge mclk_i);
    tmip <= 1'b1;
    pulse(5);
    idle;
    repeat (2) @(negedge mclk_i);
    chk(link.mip_flag, 32'h1);
    pulse(4);
    idle;
    chk(refs, 32'h2);
    chk(dones, 32'h9);
    summarize;
  end
endmodule
`default_nettype wire
